// file: rtl/mdd_cnt_if.sv
// Carrier between the request decoder and its diagnostic counter bank.
// Assumes both ends run on the same clock.
`default_nettype none

interface mdd_cnt_if;
    import mdd_pkg::*;
    logic [CNT_NUM-1:0]            evt;   // One-cycle count events
    logic                          clr;   // Clear every counter
    logic [CNT_NUM-1:0][CNT_W-1:0] cnt;   // Counter values

    modport dec  (output evt, output clr, input cnt);
    modport bank (input evt, input clr, output cnt);
endinterface : mdd_cnt_if

`default_nettype wire

// file: rtl/mdd_diag_counters.sv
// Bank of 16-bit diagnostic counters with wrap and clear.
// Assumes a synchronised active-low reset and one-cycle event pulses.
`default_nettype none

module mdd_diag_counters
    import mdd_pkg::*;
(
    input  wire logic mclk,   // System clock
    input  wire logic rst_n,  // Synchronised reset, active low
    mdd_cnt_if.bank   cb      // Events in, values out
);

    typedef struct packed {
        logic [CNT_NUM-1:0][CNT_W-1:0] cnt;
    } mdd_cnt_st_t;

    mdd_cnt_st_t st;
    mdd_cnt_st_t next_st;

    // ****************************************
    // Counting
    // ****************************************
    always_comb begin
        next_st = st;
        for (int i = 0; i < CNT_NUM; i++) begin
            if (cb.clr) begin
                next_st.cnt[i] = CNT_ZERO;                        // [RULE15]
            end else if (cb.evt[i]) begin
                // Counter never shows its top value: reaching it means zero
                if (st.cnt[i] + CNT_STEP == CNT_MAX) begin
                    next_st.cnt[i] = CNT_ZERO;                    // [RULE15]
                end else begin
                    next_st.cnt[i] = st.cnt[i] + CNT_STEP;
                end
            end
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign cb.cnt = st.cnt;

    // ****************************************
    // Checks
    // ****************************************
    a_cnt_wrap_zero: assert property (@(posedge mclk) disable iff (!rst_n) // [RULE15]
        (!cb.clr && cb.evt[CNT_REQ_OK] && st.cnt[CNT_REQ_OK] == CNT_MAX - CNT_STEP)
        |=> st.cnt[CNT_REQ_OK] == CNT_ZERO)
        else $error("request counter did not wrap to zero");

    a_cnt_clear_all: assert property (@(posedge mclk) disable iff (!rst_n) // [RULE15]
        cb.clr |=> (st.cnt == '0))
        else $error("counters not cleared");

endmodule // mdd_diag_counters

`default_nettype wire

// file: rtl/mdd_diag_request_decoder.sv
// Diagnostics request decoder: takes a request byte stream, checks and splits its fields,
// dispatches the action and streams back the echo or an exception answer.
// Assumes inputs synchronous to mclk and a response sink that takes one byte every cycle.
//
// Function
// RULE1: Request is unit, function, sub-function, words, index
// RULE2: Low operation byte selects the action
// RULE3: Codes read, clear, clear all, list ports
// RULE4: Requester zeroes operation bits fifteen to twelve
// RULE5: Bits eleven to eight hold version zero
// RULE6: Control high byte is data selection
// RULE7: Control low byte is port selector
// RULE8: Selector zero means internal port
// RULE9: Selectors one to FE are logical ports
// RULE10: Selector FF means arrival port
// RULE11: Requester uses FF when port irrelevant
// RULE12: Only port-specific selections use the selector
// RULE13: Typical request uses words 0001 and 0100
// RULE14: Defined selections 01 to 04 and 7F
// RULE15: Counters zero at top, clear, parameter change
// RULE16: Answer echoes every request field
// RULE17: Undefined or reserved values raise an exception; an undefined data selection passes without one for clear all and list ports
`default_nettype none

module mdd_diag_request_decoder
    import mdd_pkg::*;
#(
    parameter logic [7:0] NUM_PORTS = 8'h02        // Highest logical port number present
)(
    input  wire  logic       mclk,          // 125 MHz clock
    input  wire  logic       rst_n,         // Asynchronous reset, active low
    input  wire  logic       in_valid,      // Request byte present
    input  wire  logic [7:0] in_data,       // Request byte
    input  wire  logic       in_last,       // Last byte of request
    input  wire  logic [7:0] arrival_port,  // Port the request came in on
    input  wire  logic       comm_change,   // Communication parameters changed
    output var   logic       in_ready,      // Byte taken when high
    output var   logic       resp_valid,    // Answer byte present
    output var   logic [7:0] resp_data,     // Answer byte
    output var   logic       resp_last,     // Last answer byte
    output var   logic       act_read,      // Read selected data
    output var   logic       act_clear,     // Clear selected data
    output var   logic       act_clear_all, // Clear all data
    output var   logic       act_list,      // List ports
    output var   logic [7:0] act_sel,       // Data selection code
    output var   logic [7:0] act_port,      // Resolved port number
    output var   logic       act_port_used, // Port number is meaningful
    output var   logic [7:0] act_start,     // Starting entry index
    output var   logic [15:0] cnt_req_ok,   // Requests served
    output var   logic [15:0] cnt_exc,      // Exception answers
    output var   logic [15:0] cnt_bad       // Malformed frames
);

    typedef struct packed {
        mdd_state_t  state;
        logic [3:0]  idx;
        logic [7:0]  unit;
        logic [15:0] func;
        logic [15:0] subf;
        logic [15:0] op;
        logic [15:0] ctl;
        logic [7:0]  start;
        logic [7:0]  arr;
        logic        exc;
        logic [7:0]  exc_code;
        logic        in_ready;
        logic        resp_valid;
        logic        resp_last;
        logic [7:0]  resp_data;
        logic        act_read;
        logic        act_clear;
        logic        act_clear_all;
        logic        act_list;
        logic [7:0]  act_sel;
        logic [7:0]  act_port;
        logic        act_port_used;
        logic [7:0]  act_start;
        logic [CNT_NUM-1:0] evt;
        logic        cnt_clr;
    } mdd_dec_st_t;

    // ****************************************
    // Reset release
    // ****************************************
    logic [1:0] rst_pipe;
    logic       rst_sync_n;

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            rst_pipe <= 2'h0;
        end else begin
            rst_pipe <= {rst_pipe[0], 1'b1};
        end
    end

    assign rst_sync_n = rst_pipe[1];

    mdd_dec_st_t st;
    mdd_dec_st_t next_st;
    mdd_cnt_if   cnt_bus ();

    // Answer byte for a given position, echo or exception form
    function automatic logic [7:0] answer_byte(input mdd_dec_st_t s, input logic [3:0] i);
        logic [7:0] b;
        b = 8'h00;
        case (i)
            IDX_UNIT:    b = s.unit;                                  // [RULE16]
            IDX_FUNC_HI: b = s.func[15:8];
            IDX_FUNC_LO: b = s.exc ? (s.func[7:0] | EXC_FLAG) : s.func[7:0];
            IDX_SUBF_HI: b = s.exc ? s.exc_code : s.subf[15:8];       // [RULE17]
            IDX_SUBF_LO: b = s.subf[7:0];
            IDX_OP_HI:   b = s.op[15:8];
            IDX_OP_LO:   b = s.op[7:0];
            IDX_CTL_HI:  b = s.ctl[15:8];
            IDX_CTL_LO:  b = s.ctl[7:0];
            IDX_START:   b = s.start;
            default:     b = 8'h00;
        endcase
        return b;
    endfunction

    // ****************************************
    // Field decode
    // ****************************************
    logic [3:0] f_rsv;
    logic [3:0] f_pv;
    logic [7:0] f_opc;
    logic [7:0] f_ds;
    logic [7:0] f_ps;
    logic       ds_defined;
    logic       port_specific;
    logic       opc_defined;
    logic       needs_sel;

    always_comb begin
        f_rsv         = st.op[OP_RSV_HI:OP_RSV_LO];
        f_pv          = st.op[OP_PV_HI:OP_PV_LO];                    // [RULE5]
        f_opc         = st.op[OP_CODE_HI:OP_CODE_LO];                // [RULE2]
        f_ds          = st.ctl[CTL_DS_HI:CTL_DS_LO];                 // [RULE6]
        f_ps          = st.ctl[CTL_PS_HI:CTL_PS_LO];                 // [RULE7]
        ds_defined    = (f_ds == DS_BASIC) || (f_ds == DS_ETH_PORT) || (f_ds == DS_TCP502)
                        || (f_ds == DS_CONN_TABLE) || (f_ds == DS_OFFSETS); // [RULE14]
        port_specific = (f_ds == DS_ETH_PORT);                       // [RULE12]
        opc_defined   = (f_opc == OPC_READ) || (f_opc == OPC_CLEAR)
                        || (f_opc == OPC_CLEAR_ALL) || (f_opc == OPC_LIST); // [RULE3]
        needs_sel     = (f_opc == OPC_READ) || (f_opc == OPC_CLEAR);
    end

    // ****************************************
    // Sequencing
    // ****************************************
    always_comb begin
        next_st               = st;
        next_st.act_read      = 1'b0;
        next_st.act_clear     = 1'b0;
        next_st.act_clear_all = 1'b0;
        next_st.act_list      = 1'b0;
        next_st.evt           = '0;
        next_st.cnt_clr       = comm_change;                         // [RULE15]
        next_st.resp_valid    = 1'b0;
        next_st.resp_last     = 1'b0;
        case (st.state)
            ST_IDLE, ST_RECV: begin
                next_st.state    = st.state;
                next_st.in_ready = 1'b1;
                if (in_valid && st.in_ready) begin
                    next_st.state = ST_RECV;
                    if (st.idx != IDX_OVER) begin
                        next_st.idx = st.idx + 4'h1;
                    end
                    case (st.idx)                                     // [RULE1]
                        IDX_UNIT: begin
                            next_st.unit = in_data;
                            next_st.arr  = arrival_port;
                        end
                        IDX_FUNC_HI: next_st.func[15:8] = in_data;
                        IDX_FUNC_LO: next_st.func[7:0]  = in_data;
                        IDX_SUBF_HI: next_st.subf[15:8] = in_data;
                        IDX_SUBF_LO: next_st.subf[7:0]  = in_data;
                        IDX_OP_HI:   next_st.op[15:8]   = in_data;
                        IDX_OP_LO:   next_st.op[7:0]    = in_data;
                        IDX_CTL_HI:  next_st.ctl[15:8]  = in_data;
                        IDX_CTL_LO:  next_st.ctl[7:0]   = in_data;
                        IDX_START:   next_st.start      = in_data;
                        default:     next_st.start      = st.start;
                    endcase
                    if (in_last) begin
                        next_st.idx = IDX_UNIT;
                        if (st.idx == IDX_START) begin                // [RULE1]
                            next_st.state    = ST_EXEC;
                            next_st.in_ready = 1'b0;
                        end else begin
                            // Short or long frame: dropped silently, only counted
                            next_st.state          = ST_IDLE;
                            next_st.evt[CNT_BAD]   = 1'b1;
                        end
                    end
                end
            end
            ST_EXEC: begin
                next_st.exc      = 1'b1;
                next_st.exc_code = EXC_ILL_VALUE;
                if ((st.func != FUNC_DIAG) || (st.subf != SUBF_DIAG)) begin
                    next_st.exc_code = EXC_ILL_FUNC;                  // [RULE17]
                end else if ((f_rsv != OP_RSV_ZERO) || (f_pv != PV_INITIAL)) begin
                    next_st.exc_code = EXC_ILL_VALUE;                 // [RULE4] [RULE5] [RULE17]
                end else if (!opc_defined) begin
                    next_st.exc_code = EXC_ILL_FUNC;                  // [RULE17]
                end else if (needs_sel && !ds_defined) begin
                    next_st.exc_code = EXC_ILL_VALUE;                 // [RULE14] [RULE17]
                end else if (needs_sel && port_specific && (f_ps >= PS_FIRST_LOG)
                             && (f_ps <= PS_LAST_LOG) && (f_ps > NUM_PORTS)) begin
                    next_st.exc_code = EXC_ILL_VALUE;                 // [RULE9]
                end else begin
                    next_st.exc           = 1'b0;
                    next_st.act_read      = (f_opc == OPC_READ);      // [RULE3]
                    next_st.act_clear     = (f_opc == OPC_CLEAR);
                    next_st.act_clear_all = (f_opc == OPC_CLEAR_ALL);
                    next_st.act_list      = (f_opc == OPC_LIST);
                    next_st.cnt_clr       = comm_change || (f_opc == OPC_CLEAR)
                                            || (f_opc == OPC_CLEAR_ALL); // [RULE15]
                    next_st.act_sel       = f_ds;
                    next_st.act_start     = st.start;
                    next_st.act_port_used = needs_sel && port_specific; // [RULE12]
                    // Selector 00 and 01..FE pass as they are; FF names the arrival port
                    next_st.act_port      = (f_ps == PS_ARRIVAL) ? st.arr : f_ps; // [RULE8] [RULE9] [RULE10]
                    next_st.evt[CNT_REQ_OK] = 1'b1;
                end
                next_st.evt[CNT_EXC] = next_st.exc;
                next_st.state        = ST_RESP;
                next_st.idx          = IDX_FUNC_HI;
                next_st.resp_valid   = 1'b1;
                next_st.resp_data    = st.unit;                       // [RULE16]
            end
            ST_RESP: begin
                next_st.resp_valid = 1'b1;
                next_st.resp_data  = answer_byte(st, st.idx);         // [RULE16]
                next_st.idx        = st.idx + 4'h1;
                if ((st.exc && st.idx == IDX_EXC_CODE) || (!st.exc && st.idx == IDX_START)) begin
                    next_st.resp_last = 1'b1;
                    next_st.idx       = IDX_UNIT;
                    next_st.state     = ST_IDLE;
                    next_st.in_ready  = 1'b1;
                end
            end
            default: begin
                next_st = '0;
                next_st.state = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge mclk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            st       <= '0;
            st.state <= ST_IDLE;
        end else begin
            st <= next_st;
        end
    end

    // ****************************************
    // Counters and outputs
    // ****************************************
    assign cnt_bus.evt = st.evt;
    assign cnt_bus.clr = st.cnt_clr;

    mdd_diag_counters u_counters (
        .mclk  (mclk),
        .rst_n (rst_sync_n),
        .cb    (cnt_bus)
    );

    assign in_ready      = st.in_ready;
    assign resp_valid    = st.resp_valid;
    assign resp_data     = st.resp_data;
    assign resp_last     = st.resp_last;
    assign act_read      = st.act_read;
    assign act_clear     = st.act_clear;
    assign act_clear_all = st.act_clear_all;
    assign act_list      = st.act_list;
    assign act_sel       = st.act_sel;
    assign act_port      = st.act_port;
    assign act_port_used = st.act_port_used;
    assign act_start     = st.act_start;
    assign cnt_req_ok    = cnt_bus.cnt[CNT_REQ_OK];
    assign cnt_exc       = cnt_bus.cnt[CNT_EXC];
    assign cnt_bad       = cnt_bus.cnt[CNT_BAD];

    // ****************************************
    // Checks
    // ****************************************
    default clocking cb_chk @(posedge mclk); endclocking
    default disable iff (!rst_sync_n);

    logic exec_ok;
    assign exec_ok = (st.state == ST_EXEC) && (next_st.exc == 1'b0);

    sequence s_echo_head;
        resp_valid && (resp_data == $past(st.unit)) ##1 resp_valid && (resp_data == st.func[15:8]);
    endsequence

    sequence s_echo_tail;
        (resp_valid && !resp_last) [*7] ##1 (resp_valid && resp_last && resp_data == st.start);
    endsequence

    a_echo_whole: assert property (exec_ok |=> s_echo_head ##1 s_echo_tail) // [RULE16]
        else $error("echo answer malformed");

    a_exc_short: assert property (((st.state == ST_EXEC) && next_st.exc) // [RULE17]
        |=> resp_valid ##1 resp_valid ##1 (resp_data[7] && resp_valid) ##1 (resp_valid && resp_last))
        else $error("exception answer malformed");

    a_rsv_bits_exc: assert property (((st.state == ST_EXEC) && st.func == FUNC_DIAG // [RULE4]
        && st.subf == SUBF_DIAG && f_rsv != OP_RSV_ZERO) |=> ##3 resp_data == EXC_ILL_VALUE)
        else $error("reserved bits accepted");

    a_pv_exc: assert property (((st.state == ST_EXEC) && f_pv != PV_INITIAL) // [RULE5]
        |=> !act_read && !act_clear && !act_clear_all && !act_list)
        else $error("unknown version dispatched");

    a_opc_dispatch: assert property (exec_ok |=> // [RULE3]
        (act_read == ($past(f_opc) == OPC_READ)) && (act_list == ($past(f_opc) == OPC_LIST))
        && (act_clear_all == ($past(f_opc) == OPC_CLEAR_ALL)))
        else $error("operation code dispatched wrongly");

    a_sel_field: assert property (exec_ok |=> act_sel == $past(st.ctl[CTL_DS_HI:CTL_DS_LO])) // [RULE6]
        else $error("selection code wrong");

    a_port_arrival: assert property ((exec_ok && f_ps == PS_ARRIVAL) |=> act_port == $past(st.arr)) // [RULE10]
        else $error("arrival port not substituted");

    a_port_direct: assert property ((exec_ok && f_ps != PS_ARRIVAL) |=> act_port == $past(f_ps)) // [RULE8]
        else $error("port selector altered");

    a_port_unused: assert property ((exec_ok && f_ds != DS_ETH_PORT) |=> !act_port_used) // [RULE12]
        else $error("port marked used for non-port data");

    a_ds_reserved: assert property (((st.state == ST_EXEC) && needs_sel && !ds_defined) // [RULE14]
        |=> !act_read && !act_clear)
        else $error("reserved selection dispatched");

    a_frame_len: assert property ((st.in_ready && in_valid && in_last && st.idx != IDX_START) // [RULE1]
        |=> st.state == ST_IDLE && !resp_valid)
        else $error("bad length frame executed");

endmodule // mdd_diag_request_decoder

`default_nettype wire

// file: rtl/mdd_pkg.sv
// Constants, field layout and state codes of the diagnostics request decoder.
// Assumes a byte stream that carries whole requests, most significant byte first.
`default_nettype none

package mdd_pkg;

    // ****************************************
    // Request layout
    // ****************************************
    localparam logic [15:0] FUNC_DIAG    = 16'h0008;
    localparam logic [15:0] SUBF_DIAG    = 16'h0016;
    localparam logic [3:0]  IDX_UNIT     = 4'h0;
    localparam logic [3:0]  IDX_FUNC_HI  = 4'h1;
    localparam logic [3:0]  IDX_FUNC_LO  = 4'h2;
    localparam logic [3:0]  IDX_SUBF_HI  = 4'h3;
    localparam logic [3:0]  IDX_SUBF_LO  = 4'h4;
    localparam logic [3:0]  IDX_OP_HI    = 4'h5;
    localparam logic [3:0]  IDX_OP_LO    = 4'h6;
    localparam logic [3:0]  IDX_CTL_HI   = 4'h7;
    localparam logic [3:0]  IDX_CTL_LO   = 4'h8;
    localparam logic [3:0]  IDX_START    = 4'h9;
    localparam logic [3:0]  IDX_OVER     = 4'hA;
    localparam logic [3:0]  IDX_EXC_CODE = 4'h3;

    // ****************************************
    // Operation word and control word fields
    // ****************************************
    localparam int          OP_RSV_HI    = 15;
    localparam int          OP_RSV_LO    = 12;
    localparam int          OP_PV_HI     = 11;
    localparam int          OP_PV_LO     = 8;
    localparam int          OP_CODE_HI   = 7;
    localparam int          OP_CODE_LO   = 0;
    localparam int          CTL_DS_HI    = 15;
    localparam int          CTL_DS_LO    = 8;
    localparam int          CTL_PS_HI    = 7;
    localparam int          CTL_PS_LO    = 0;
    localparam logic [3:0]  OP_RSV_ZERO  = 4'h0;
    localparam logic [3:0]  PV_INITIAL   = 4'h0;

    localparam logic [7:0]  OPC_READ      = 8'h01;
    localparam logic [7:0]  OPC_CLEAR     = 8'h02;
    localparam logic [7:0]  OPC_CLEAR_ALL = 8'h03;
    localparam logic [7:0]  OPC_LIST      = 8'h04;

    localparam logic [7:0]  DS_BASIC      = 8'h01;
    localparam logic [7:0]  DS_ETH_PORT   = 8'h02;
    localparam logic [7:0]  DS_TCP502     = 8'h03;
    localparam logic [7:0]  DS_CONN_TABLE = 8'h04;
    localparam logic [7:0]  DS_OFFSETS    = 8'h7F;

    localparam logic [7:0]  PS_INTERNAL   = 8'h00;
    localparam logic [7:0]  PS_FIRST_LOG  = 8'h01;
    localparam logic [7:0]  PS_LAST_LOG   = 8'hFE;
    localparam logic [7:0]  PS_ARRIVAL    = 8'hFF;

    // ****************************************
    // Exception answer
    // ****************************************
    localparam logic [7:0]  EXC_FLAG      = 8'h80;
    localparam logic [7:0]  EXC_ILL_FUNC  = 8'h01;
    localparam logic [7:0]  EXC_ILL_VALUE = 8'h03;

    // ****************************************
    // Diagnostic counters
    // ****************************************
    localparam int          CNT_W         = 16;
    localparam int          CNT_NUM       = 3;
    localparam logic [15:0] CNT_MAX       = 16'hFFFF;
    localparam logic [15:0] CNT_ZERO      = 16'h0000;
    localparam logic [15:0] CNT_STEP      = 16'h0001;
    localparam int          CNT_REQ_OK    = 0;
    localparam int          CNT_EXC       = 1;
    localparam int          CNT_BAD       = 2;

    typedef enum logic [3:0] {
        ST_IDLE = 4'b0001,
        ST_RECV = 4'b0010,
        ST_EXEC = 4'b0100,
        ST_RESP = 4'b1000
    } mdd_state_t;

endpackage : mdd_pkg

`default_nettype wire

// file: verification/mdd_client_model.sv
// Request source standing in for the remote client.
// Assumes the bench gives a whole frame and a one-cycle start.
`default_nettype none
module mdd_client_model (
    input  wire logic            mclk,     // Clock
    input  wire logic            start,    // Send one frame
    input  wire logic [9:0][7:0] req,      // Frame, byte 9 first
    input  wire logic [3:0]      len,      // Bytes to send
    input  wire logic            in_ready, // Byte taken
    output var  logic            in_valid, // Byte offered
    output var  logic [7:0]      in_data,  // Byte
    output var  logic            in_last   // Final byte
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] idx = 4'h0;
    initial in_valid = 1'b0;
    // Idle data is inverted so a stale byte never looks fresh
    assign in_data = in_valid ? req[4'h9 - idx] : ~req[0];
    assign in_last = in_valid && (idx == len - 4'h1);
    always @(posedge mclk) begin
        if (in_valid && in_ready) begin
            idx <= idx + 4'h1;
            if (in_last) in_valid <= 1'b0;
        end else if (start && !in_valid) begin
            idx      <= 4'h0;
            in_valid <= 1'b1;
        end
    end
endmodule // mdd_client_model
`default_nettype wire

// file: verification/mdd_diag_request_decoder_tb.sv
// Bench for the request decoder, fed by the client model.
// Assumes the whole answer ends within 60 cycles of the request.
`default_nettype none
module mdd_diag_request_decoder_tb;
    import mdd_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic mclk = 1'b0, rst_n = 1'b0, start = 1'b0, comm_change = 1'b0, a_used;
    logic [9:0][7:0] req = '0;
    logic [3:0] len = 4'hA, acts;
    logic [7:0] arrival_port = 8'h05, a_port, a_sel, a_start, in_data, resp_data, act_sel, act_port, act_start;
    logic in_valid, in_last, in_ready, resp_valid, resp_last, act_read, act_clear, act_clear_all, act_list;
    logic act_port_used;
    logic [15:0] cnt_req_ok, cnt_exc, cnt_bad, c0;
    logic [7:0] got[$];
    int error_cnt = 0, check_count = 0;
    mdd_client_model mdd_client_model_inst (.mclk, .start, .req, .len, .in_ready, .in_valid, .in_data, .in_last);
    mdd_diag_request_decoder #(.NUM_PORTS(8'h02)) mdd_diag_request_decoder_inst (.mclk, .rst_n, .in_valid,
        .in_data, .in_last, .arrival_port, .comm_change, .in_ready, .resp_valid, .resp_data, .resp_last,
        .act_read, .act_clear, .act_clear_all, .act_list, .act_sel, .act_port, .act_port_used, .act_start,
        .cnt_req_ok, .cnt_exc, .cnt_bad);
    initial forever #4 mclk = ~mclk;
    // ********
    // Tasks
    // ********
    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] s);
        check_count++;
        if (s !== e) begin
            error_cnt++;
            $display("[FAIL] %s expected %h seen %h", nm, e, s);
        end
    endtask
    task automatic final_report();
        $display("checks %0d errors %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    function automatic logic [9:0][7:0] mk(input logic [15:0] op, input logic [15:0] ctl);
        return {8'hFF, FUNC_DIAG, SUBF_DIAG, op, ctl, 8'h07};
    endfunction
    // Bounded wait: a missing answer shows as a short byte count
    task automatic xfer(input logic [9:0][7:0] f, input logic [3:0] n);
        got.delete();
        acts = 4'h0;
        req <= f;
        len <= n;
        start <= 1'b1;
        @(posedge mclk);
        start <= 1'b0;
        repeat (60) begin
            @(posedge mclk);
            if (resp_valid === 1'b1) got.push_back(resp_data);
            if ((act_read | act_clear | act_clear_all | act_list) === 1'b1) begin
                acts = {act_read, act_clear, act_clear_all, act_list};
                {a_sel, a_port, a_used, a_start} = {act_sel, act_port, act_port_used, act_start};
            end
            if ((resp_valid & resp_last) === 1'b1) break;
        end
    endtask
    task automatic t_typical();
        xfer(mk(16'h0001, 16'h0100), 4'hA);
        chk("echo_len", 16'd10, 16'(got.size()));
        for (int i = 0; i < 10; i++) chk("echo", {8'h0, req[9 - i]}, {8'h0, got[i]});
        chk("action", 16'h8, {12'h0, acts});
        chk("sel", 16'h1, {8'h0, a_sel});
        chk("start", 16'h7, {8'h0, a_start});
        chk("cnt_live", 16'h1, cnt_req_ok);
        comm_change <= 1'b1;
        @(posedge mclk);
        comm_change <= 1'b0;
        repeat (4) @(posedge mclk);
        chk("cnt_clear", 16'h0, cnt_req_ok);
    endtask
    task automatic t_ops();
        for (int op = 1; op <= 4; op++) begin
            xfer(mk(16'(op), 16'h03FF), 4'hA);
            chk("op_action", 16'(4'h8 >> (op - 1)), {12'h0, acts});
        end
    endtask
    task automatic t_ports();
        logic [7:0] ps [3] = '{8'h00, 8'h02, 8'hFF};
        logic [7:0] ep [3] = '{8'h00, 8'h02, 8'h05};
        for (int i = 0; i < 3; i++) begin
            xfer(mk(16'h0001, {DS_ETH_PORT, ps[i]}), 4'hA);
            chk("port", {8'h0, ep[i]}, {8'h0, a_port});
            chk("port_used", 16'h1, {15'h0, a_used});
        end
        xfer(mk(16'h0001, 16'h01FF), 4'hA);
        chk("port_unused", 16'h0, {15'h0, a_used});
    endtask
    task automatic t_exc();
        logic [15:0] op [5] = '{16'h1001, 16'h0101, 16'h0005, 16'h0001, 16'h0001};
        logic [15:0] ct [5] = '{16'h0100, 16'h0100, 16'h0100, 16'h8000, 16'h0203};
        logic [7:0] cd [5] = '{EXC_ILL_VALUE, EXC_ILL_VALUE, EXC_ILL_FUNC, EXC_ILL_VALUE, EXC_ILL_VALUE};
        c0 = cnt_exc;
        for (int i = 0; i < 5; i++) begin
            xfer(mk(op[i], ct[i]), 4'hA);
            chk("exc_len", 16'd4, 16'(got.size()));
            chk("exc_func", {8'h0, FUNC_DIAG[7:0] | EXC_FLAG}, {8'h0, got[2]});
            chk("exc_code", {8'h0, cd[i]}, {8'h0, got[3]});
            chk("exc_cnt", c0 + 16'(i + 1), cnt_exc);
            chk("exc_action", 16'h0, {12'h0, acts});
        end
    endtask
    task automatic t_short();
        c0 = cnt_bad;
        xfer(mk(16'h0001, 16'h0100), 4'h9);
        chk("short_resp", 16'h0, 16'(got.size()));
        chk("bad_cnt", c0 + 16'h1, cnt_bad);
        chk("ready_kept", 16'h1, {15'h0, in_ready});
    endtask
    initial begin
        repeat (4) @(posedge mclk);
        rst_n <= 1'b1;
        repeat (4) @(posedge mclk);
        t_typical();
        t_ops();
        t_ports();
        t_exc();
        t_short();
        final_report();
    end
    initial begin
        repeat (20000) @(posedge mclk);
        error_cnt++;
        final_report();
    end
endmodule // mdd_diag_request_decoder_tb
`default_nettype wire
